// *** rtl/macrocell_map.svh ***
`ifndef MACROCELL_MAP_SVH
`define MACROCELL_MAP_SVH

`define MC_COUNT        128
`define PT_PER_MC       5
`define PT_IDX_W        3
`define REGION_MC       16
`define BLOCK_INPUTS    40
`define CHAIN_MAX_PT    40
`define CHAIN_COUNT     8
`define GCLK_COUNT      3
`define GCLK_SEL_W      2
`define DED_COUNT       4
`define DED_SEL_W       2
`define IO_COUNT        96
`define SIG_W           16

`define KIND_W          3
`define KIND_SEL        3'h0
`define KIND_TERM       3'h1
`define KIND_MODE       3'h2
`define KIND_SIG        3'h3
`define KIND_FUSE       3'h4
`define KIND_ERASE      3'h5

`define SIG_RESET       16'h0000

`endif

// *** rtl/macrocell_pkg.sv ***
`include "macrocell_map.svh"

package macrocell_pkg;

  typedef enum logic [1:0] {
    XSEL_PT   = 2'h0,
    XSEL_LOW  = 2'h1,
    XSEL_HIGH = 2'h2
  } xor_sel_t;

  typedef enum logic [1:0] {
    STORE_D  = 2'h0,
    STORE_T  = 2'h1,
    STORE_JK = 2'h2
  } store_t;

  typedef struct packed {
    logic [`DED_SEL_W-1:0]  oe_pin;
    logic                   oe_en;
    logic [`DED_SEL_W-1:0]  rst_pin;
    logic                   rst_en;
    logic [`GCLK_SEL_W-1:0] clk_sel;
    logic [`PT_IDX_W-1:0]   xor_pt;
    logic [`PT_IDX_W-1:0]   fold_pt;
    logic [`PT_PER_MC-1:0]  route;
    store_t                 store;
    xor_sel_t               xsel;
    logic                   cas_en;
    logic                   en;
  } mc_mode_t;

endpackage : macrocell_pkg

// *** rtl/product_term.sv ***
module product_term
  import macrocell_pkg::*;
#(
  parameter int W = 56
) (
  input  wire logic [W-1:0] sig,
  input  wire logic [W-1:0] use_mask,
  input  wire logic [W-1:0] inv_mask,
  output logic              term
);

  // a term with no inputs selected stays low so it never floods an or sum
  assign term = (|use_mask) & (&(~use_mask | (sig ^ inv_mask)));

endmodule : product_term

// *** rtl/macrocell_array.sv ***
`include "macrocell_map.svh"

module macrocell_array
  import macrocell_pkg::*;
#(
  parameter int MC      = `MC_COUNT,
  parameter int N_IO    = `IO_COUNT,
  parameter int N_DED   = `DED_COUNT,
  parameter int N_GCLK  = `GCLK_COUNT,
  parameter int PT      = `PT_PER_MC,
  parameter int RMC     = `REGION_MC,
  parameter int BI      = `BLOCK_INPUTS,
  parameter int CHAIN   = `CHAIN_MAX_PT,
  parameter int CFG_W   = 2 * (`BLOCK_INPUTS + `REGION_MC),
  parameter int IDX_W   = $clog2(`MC_COUNT),
  parameter int SLOT_W  = $clog2(`BLOCK_INPUTS)
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              run_en,
  input  wire logic              cfg_we,
  input  wire logic [`KIND_W-1:0] cfg_kind,
  input  wire logic [IDX_W-1:0]  cfg_index,
  input  wire logic [SLOT_W-1:0] cfg_slot,
  input  wire logic [CFG_W-1:0]  cfg_data,
  input  wire logic              rd_req,
  input  wire logic [`KIND_W-1:0] rd_kind,
  input  wire logic [IDX_W-1:0]  rd_index,
  input  wire logic [SLOT_W-1:0] rd_slot,
  output logic                   rd_valid,
  output logic                   rd_denied,
  output logic [CFG_W-1:0]       rd_data,
  output logic                   fuse_set,
  input  wire logic [N_DED-1:0]  ded_in,
  input  wire logic [N_IO-1:0]   io_in,
  input  wire logic [N_GCLK-1:0] gclk,
  input  wire logic [MC-1:0]     mc_q,
  output logic [MC-1:0]          mc_d,
  output logic [MC*PT-1:0]       mc_ctrl_pt,
  output logic [MC-1:0]          mc_clk,
  output logic [MC-1:0]          mc_rst,
  output logic [MC-1:0]          mc_oe,
  output logic [MC-1:0]          mc_active
);

  localparam int NB    = MC / RMC;
  localparam int G     = N_DED + N_IO + MC;
  localparam int SW    = $clog2(G);
  localparam int TW    = BI + RMC;
  localparam int LINKS = CHAIN / PT;
  localparam int DW    = $clog2(LINKS + 1);
  localparam int MW    = $bits(mc_mode_t);

  typedef struct packed {
    logic [NB-1:0][BI-1:0][SW-1:0] sel;
    logic [MC-1:0][PT-1:0][TW-1:0] use_m;
    logic [MC-1:0][PT-1:0][TW-1:0] inv_m;
    mc_mode_t [MC-1:0]             mode;
    logic [`SIG_W-1:0]             sig;
    logic                          fuse;
    logic [MC-1:0]                 d;
    logic                          rd_valid;
    logic                          rd_denied;
    logic [CFG_W-1:0]              rd_data;
  } state_t;

  state_t st;
  state_t next_st;

  logic [G-1:0]              gbus;
  logic [NB-1:0][BI-1:0]     blk_in;
  logic [NB-1:0][RMC-1:0]    region_bus;
  logic [NB-1:0][TW-1:0]     term_in;
  logic [MC-1:0][PT-1:0]     pt;
  logic [MC-1:0]             fold;
  logic [MC-1:0]             local_sum;
  logic [MC-1:0]             sum;
  logic [MC-1:0][DW-1:0]     depth;
  logic [MC-1:0]             xor_b;
  logic [MC-1:0]             d_comb;
  logic [MC-1:0]             en_vec;

  // only the stored feedback enters the bus, so no loop forms through it; foldback terms return combinationally via region_bus
  assign gbus = {mc_q & en_vec, io_in, ded_in};

  genvar b, s, m, t;
  generate
    for (b = 0; b < NB; b++) begin : g_blk
      for (s = 0; s < BI; s++) begin : g_sel
        assign blk_in[b][s] = (int'(st.sel[b][s]) < G) ? gbus[st.sel[b][s]] : 1'b0;
      end
      assign region_bus[b] = fold[b*RMC +: RMC];
      assign term_in[b]    = {region_bus[b], blk_in[b]};
    end
    for (m = 0; m < MC; m++) begin : g_mc
      assign en_vec[m] = st.mode[m].en;
      for (t = 0; t < PT; t++) begin : g_pt
        product_term #(.W(TW)) u_pt (
          .sig      (term_in[m/RMC]),
          .use_mask (st.use_m[m][t]),
          .inv_mask (st.inv_m[m][t]),
          .term     (pt[m][t])
        );
        assign mc_ctrl_pt[m*PT+t] = en_vec[m] & pt[m][t] & ~st.mode[m].route[t];
      end
      // a term index past the last term picks nothing rather than an unknown
      assign fold[m] = en_vec[m] & (int'(st.mode[m].fold_pt) < PT)
                       & ~pt[m][st.mode[m].fold_pt];
      assign local_sum[m] = en_vec[m] & (|(pt[m] & st.mode[m].route));
      assign mc_clk[m] = en_vec[m] & (int'(st.mode[m].clk_sel) < N_GCLK)
                         & gclk[st.mode[m].clk_sel];
      assign mc_rst[m] = en_vec[m] & st.mode[m].rst_en & ded_in[st.mode[m].rst_pin];
      assign mc_oe[m]  = en_vec[m] & st.mode[m].oe_en & ded_in[st.mode[m].oe_pin];
    end
  endgenerate

  // a chain runs along neighbours of one block and stops after LINKS macrocells; a block can hold several chains
  always_comb begin
    for (int i = 0; i < MC; i++) begin
      sum[i]   = local_sum[i];
      depth[i] = DW'(1);
      if ((i % RMC) != 0 && en_vec[i] && st.mode[i].cas_en
          && int'(depth[i-1]) < LINKS) begin
        sum[i]   = local_sum[i] | sum[i-1];
        depth[i] = depth[i-1] + DW'(1);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < MC; i++) begin
      case (st.mode[i].xsel)
        XSEL_PT:   xor_b[i] = (int'(st.mode[i].xor_pt) < PT) & pt[i][st.mode[i].xor_pt];
        XSEL_LOW:  xor_b[i] = 1'b0;
        XSEL_HIGH: xor_b[i] = 1'b1;
        default:   xor_b[i] = 1'b0;
      endcase
      case (st.mode[i].store)
        STORE_D:  d_comb[i] = sum[i] ^ xor_b[i];
        STORE_T:  d_comb[i] = sum[i] ^ mc_q[i];
        STORE_JK: d_comb[i] = (sum[i] & ~mc_q[i])
                              | (~((int'(st.mode[i].xor_pt) < PT) & pt[i][st.mode[i].xor_pt])
                                 & mc_q[i]);
        default:  d_comb[i] = sum[i] ^ xor_b[i];
      endcase
      d_comb[i] = d_comb[i] & en_vec[i];
    end
  end

  always_comb begin
    next_st           = st;
    next_st.d         = d_comb;
    next_st.rd_valid  = 1'b0;
    next_st.rd_denied = 1'b0;
    next_st.rd_data   = '0;
    // writes while running are dropped so the logic never sees a half loaded mode
    if (cfg_we && !run_en) begin
      case (cfg_kind)
        `KIND_SEL: begin
          if (int'(cfg_index) < NB && int'(cfg_slot) < BI) begin
            next_st.sel[cfg_index][cfg_slot] = cfg_data[SW-1:0];
          end
        end
        `KIND_TERM: begin
          if (int'(cfg_slot) < PT) begin
            next_st.use_m[cfg_index][cfg_slot] = cfg_data[CFG_W-1:TW];
            next_st.inv_m[cfg_index][cfg_slot] = cfg_data[TW-1:0];
          end
        end
        `KIND_MODE: next_st.mode[cfg_index] = mc_mode_t'(cfg_data[MW-1:0]);
        `KIND_SIG:  next_st.sig = cfg_data[`SIG_W-1:0];
        `KIND_FUSE: next_st.fuse = 1'b1;
        `KIND_ERASE: begin
          next_st.sel   = '0;
          next_st.use_m = '0;
          next_st.inv_m = '0;
          next_st.mode  = '0;
          next_st.sig   = `SIG_RESET;
          next_st.fuse  = 1'b0;
        end
        default: next_st.fuse = st.fuse;
      endcase
    end
    if (rd_req) begin
      next_st.rd_valid = 1'b1;
      case (rd_kind)
        `KIND_SIG:  next_st.rd_data = CFG_W'(st.sig);
        `KIND_FUSE: next_st.rd_data = CFG_W'(st.fuse);
        `KIND_SEL: begin
          if (int'(rd_index) < NB && int'(rd_slot) < BI) begin
            next_st.rd_data = CFG_W'(st.sel[rd_index][rd_slot]);
          end
        end
        `KIND_TERM: begin
          if (int'(rd_slot) < PT) begin
            next_st.rd_data = {st.use_m[rd_index][rd_slot], st.inv_m[rd_index][rd_slot]};
          end
        end
        `KIND_MODE: next_st.rd_data = CFG_W'(st.mode[rd_index]);
        default:    next_st.rd_data = '0;
      endcase
      if (st.fuse && rd_kind != `KIND_SIG && rd_kind != `KIND_FUSE) begin
        next_st.rd_denied = 1'b1;
        next_st.rd_data   = '0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mc_d      = st.d;
  assign mc_active = en_vec;
  assign rd_valid  = st.rd_valid;
  assign rd_denied = st.rd_denied;
  assign rd_data   = st.rd_data;
  assign fuse_set  = st.fuse;

  a_unused_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 ((mc_d & ~$past(en_vec)) == '0))
    else $error("disabled macrocell drives data");

  a_cfg_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
    run_en |=> ($stable(st.mode) && $stable(st.use_m) && $stable(st.sel)))
    else $error("configuration changed while running");

  a_fuse_blocks: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_req && st.fuse && rd_kind == `KIND_MODE) |=> (rd_valid && rd_denied && rd_data == '0))
    else $error("configuration read despite fuse");

  a_sig_readable: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rd_req && rd_kind == `KIND_SIG) |=> (rd_valid && !rd_denied
      && rd_data == CFG_W'($past(st.sig))))
    else $error("signature not readable");

  a_polarity_inv: assert property (@(posedge core_clk) disable iff (sys_rst)
    (en_vec[0] && st.mode[0].xsel == XSEL_HIGH && st.mode[0].store == STORE_D)
      |=> (mc_d[0] == !$past(sum[0])))
    else $error("high xor input did not invert sum");

  a_toggle_emul: assert property (@(posedge core_clk) disable iff (sys_rst)
    (en_vec[0] && st.mode[0].store == STORE_T) |=> (mc_d[0] == ($past(sum[0]) ^ $past(mc_q[0]))))
    else $error("toggle emulation wrong");

  a_chain_depth: assert property (@(posedge core_clk) disable iff (sys_rst)
    (int'(depth[RMC-1]) <= LINKS) && (int'(depth[MC-1]) <= LINKS))
    else $error("cascade chain exceeds term limit");

  a_fold_inverse: assert property (@(posedge core_clk) disable iff (sys_rst)
    en_vec[1] |-> (region_bus[0][1] == !pt[1][st.mode[1].fold_pt]))
    else $error("foldback not inverse of its term");

  a_ctrl_route: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mc_ctrl_pt[PT-1:0] & st.mode[0].route) == '0)
    else $error("term routed to both or sum and control");

  a_clk_pick: assert property (@(posedge core_clk) disable iff (sys_rst)
    en_vec[0] |-> (mc_clk[0] == gclk[st.mode[0].clk_sel]))
    else $error("macrocell clock not the selected global clock");

endmodule : macrocell_array

// *** bench/board_pins.sv ***
module board_pins (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [95:0] io_req,
  output logic [95:0]      io_in,
  output logic [3:0]       ded_in,
  output logic [2:0]       gclk
);
  timeunit 1ns;
  timeprecision 1ps;
  // io pins lag the request by one edge, like a registered board driver; ded_in and gclk just count up
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_in  <= '0;
      ded_in <= '0;
      gclk   <= '0;
    end else begin
      io_in  <= io_req;
      ded_in <= ded_in + 4'h1;
      gclk   <= gclk + 3'h1;
    end
  end
endmodule : board_pins

// *** bench/macrocell_sum_of_products_tb.sv ***
module macrocell_sum_of_products_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import macrocell_pkg::*;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
  typedef struct {int due; int sel; logic [17:0] val;} note_t;
  logic         core_clk, sys_rst, run_en, cfg_we, rd_req, rd_valid, rd_denied, fuse_set;
  logic [2:0]   cfg_kind, rd_kind, gclk;
  logic [6:0]   cfg_index, rd_index;
  logic [5:0]   cfg_slot, rd_slot;
  logic [111:0] cfg_data, rd_data;
  logic [3:0]   ded_in;
  logic [95:0]  io_in, io_req;
  logic [127:0] mc_q, mc_d, mc_clk, mc_rst, mc_oe, mc_active;
  logic [639:0] mc_ctrl_pt;
  logic [15:0]  sig;
  int           num_errors, comparisons, cyc;
  note_t        q[$];
  bit           casc;
  mc_mode_t     mm;

  macrocell_array DUT (.core_clk(core_clk), .sys_rst(sys_rst), .run_en(run_en),
    .cfg_we(cfg_we), .cfg_kind(cfg_kind), .cfg_index(cfg_index), .cfg_slot(cfg_slot),
    .cfg_data(cfg_data), .rd_req(rd_req), .rd_kind(rd_kind), .rd_index(rd_index),
    .rd_slot(rd_slot), .rd_valid(rd_valid), .rd_denied(rd_denied), .rd_data(rd_data),
    .fuse_set(fuse_set), .ded_in(ded_in), .io_in(io_in), .gclk(gclk), .mc_q(mc_q),
    .mc_d(mc_d), .mc_ctrl_pt(mc_ctrl_pt), .mc_clk(mc_clk), .mc_rst(mc_rst),
    .mc_oe(mc_oe), .mc_active(mc_active));
  board_pins partner (.core_clk(core_clk), .sys_rst(sys_rst), .io_req(io_req),
    .io_in(io_in), .ded_in(ded_in), .gclk(gclk));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [17:0] obs(int s);
    case (s)
      0: return {16'h0, mc_d[1:0]};
      1: return {rd_valid, rd_denied, rd_data[15:0]};
      2: return {13'h0, mc_ctrl_pt[4:0]};
      // control picks against the live pins; zero when each pick follows its pin
      4: return {14'h0, fuse_set, mc_clk[0] ^ gclk[2], mc_rst[0] ^ ded_in[1],
                 mc_oe[0] ^ ded_in[3]};
      default: return {16'h0, mc_active[1:0]};
    endcase
  endfunction : obs

  // results settle by the falling edge; notes come due in order
  always @(negedge core_clk) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      `CHK(obs(q[0].sel), q[0].val)
      void'(q.pop_front());
    end
    cyc++;
  end

  task automatic note(int s, logic [17:0] v, int lat);
    q.push_back('{cyc + lat, s, v});
  endtask : note

  function automatic logic [111:0] mode(logic en, logic cas, logic [1:0] xs,
                                        logic [1:0] st, logic [4:0] rt);
    mc_mode_t m;
    m = '0;
    m.en = en;
    m.cas_en = cas;
    m.xsel = xor_sel_t'(xs);
    m.store = store_t'(st);
    m.route = rt;
    return 112'(m);
  endfunction : mode

  task automatic cfg(logic [2:0] k, logic [6:0] idx, logic [5:0] sl, logic [111:0] d);
    @(posedge core_clk);
    cfg_we <= 1'b1;
    cfg_kind <= k;
    cfg_index <= idx;
    cfg_slot <= sl;
    cfg_data <= d;
    @(posedge core_clk);
    cfg_we <= 1'b0;
  endtask : cfg

  task automatic rd(logic [2:0] k, logic [17:0] v);
    @(posedge core_clk);
    rd_req <= 1'b1;
    rd_kind <= k;
    note(1, v, 1);
    @(posedge core_clk);
    rd_req <= 1'b0;
  endtask : rd

  task automatic run(logic [1:0] xs, logic [1:0] st, logic [4:0] rt);
    logic [95:0]  r;
    logic [127:0] qv;
    logic         s, d;
    cfg(3'h2, 7'h0, 6'h0, mode(1'b1, 1'b0, xs, st, rt));
    repeat (6) begin
      r = {$urandom, $urandom, $urandom};
      qv = {4{$urandom}};
      s = |(r[4:0] & rt);
      case (st)
        2'h1: d = s ^ qv[0];
        2'h2: d = (s & ~qv[0]) | (~r[0] & qv[0]);
        default: d = (xs == 2'h0) ? s ^ r[0] : (xs == 2'h2) ? ~s : s;
      endcase
      @(posedge core_clk);
      io_req <= r;
      mc_q <= qv;
      note(2, {13'h0, r[4:0] & ~rt}, 1);
      note(0, {16'h0, casc & s, d}, 2);
      @(posedge core_clk);
    end
    $display("test mode %0d store %0d route %h done", xs, st, rt);
  endtask : run

  task automatic final_report;
    if (q.size() != 0) num_errors++;
    $display("counts: %0d compares, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("[FAIL] %0t run did not finish", $time);
    final_report;
  end

  initial begin
    {sys_rst, run_en, cfg_we, rd_req, casc} = 5'b10000;
    {cfg_kind, cfg_index, cfg_slot, cfg_data} = '0;
    {rd_kind, rd_index, rd_slot, io_req, mc_q} = '0;
    void'($urandom(14790));
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    note(3, 18'h0, 0);
    for (int s = 0; s < 5; s++) begin
      cfg(3'h0, 7'h0, 6'(s), 112'(4 + s));
      cfg(3'h1, 7'h0, 6'(s), 112'(1) << (56 + s));
    end
    run(2'h1, 2'h0, 5'h1f);
    run(2'h2, 2'h0, 5'h1f);
    run(2'h0, 2'h0, 5'h1f);
    run(2'h1, 2'h1, 5'h1f);
    run(2'h1, 2'h2, 5'h1f);
    run(2'h1, 2'h0, 5'h05);
    cfg(3'h2, 7'h1, 6'h0, mode(1'b1, 1'b1, 2'h1, 2'h0, 5'h00));
    casc = 1'b1;
    note(3, 18'h3, 0);
    run(2'h1, 2'h0, 5'h1f);
    run_en <= 1'b1;
    cfg(3'h2, 7'h0, 6'h0, mode(1'b0, 1'b0, 2'h1, 2'h0, 5'h1f));
    run_en <= 1'b0;
    note(3, 18'h3, 0);
    $display("test frozen config done");
    sig = 16'($urandom);
    cfg(3'h3, 7'h0, 6'h0, 112'(sig));
    rd(3'h3, {2'b10, sig});
    cfg(3'h4, 7'h0, 6'h0, 112'h0);
    rd(3'h2, 18'h30000);
    rd(3'h3, {2'b10, sig});
    cfg(3'h5, 7'h0, 6'h0, 112'h0);
    note(3, 18'h0, 0);
    repeat (4) @(posedge core_clk);
    $display("test fuse and erase done");
    mm = '0;
    mm.en = 1'b1;
    mm.clk_sel = 2'h2;
    mm.rst_en = 1'b1;
    mm.rst_pin = 2'h1;
    mm.oe_en = 1'b1;
    mm.oe_pin = 2'h3;
    cfg(3'h2, 7'h0, 6'h0, 112'(mm));
    repeat (8) begin
      note(4, 18'h0, 0);
      @(posedge core_clk);
    end
    $display("test control picks done");
    final_report;
  end
endmodule : macrocell_sum_of_products_tb
